// File: common/prr_pkg.sv
/*
 * Package for the port reset and input control block: register map,
 * reset values and field positions.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package prr_pkg;
  localparam int unsigned PRR_NPORT = 4;
  localparam int unsigned PRR_PW = 16;
  // Port index of the shared analog/digital ports
  localparam int unsigned PRR_ANA_A = 2;
  localparam int unsigned PRR_ANA_B = 3;
  // Register offsets; each port owns a 0x20-byte slot
  localparam logic [11:0] PRR_SLOT_STRIDE = 12'h020;
  localparam logic [2:0] PRR_IDX_UPPER_PIN_CONTROL = 3'h0;
  localparam logic [2:0] PRR_IDX_DIGITAL_INPUT_DISABLE = 3'h1;
  localparam logic [2:0] PRR_IDX_PAD_DRIVER_LOW = 3'h2;
  localparam logic [2:0] PRR_IDX_PAD_DRIVER_HIGH = 3'h3;
  localparam logic [2:0] PRR_IDX_PIN_INPUT = 3'h4;
  localparam logic [11:0] PRR_OFF_PERIPHERAL_RESET_SET = 12'h100;
  localparam logic [11:0] PRR_OFF_RESET_STATUS = 12'h104;
  localparam int unsigned PRR_BIT_PORT_RESET_REQUEST = 0;
  // Reset values
  localparam logic [31:0] PRR_UPC_SYS_RST = 32'h0000_0000;
  localparam logic [31:0] PRR_UPC_MOD_RST = 32'h2020_2020;
  localparam logic [31:0] PRR_PDR_SYS_RST = 32'h2222_2222;
  localparam logic [31:0] PRR_PDR_MOD_RST = 32'h0000_0000;
  localparam logic [31:0] PRR_DID_MOD_RST = 32'h0000_0000;
  // Pins present per port after system reset; arbitrary default
  localparam logic [15:0] PRR_DID_SYS_RST [PRR_NPORT] = '{
    16'hF000, 16'hFF00, 16'hFFFF, 16'hFFFF};
  // Write-locked bits of the second analog port
  localparam logic [15:0] PRR_ANA_B_LOCK = 16'h0030;
  localparam logic [1:0] PRR_RESP_OKAY = 2'b00;
  localparam logic [1:0] PRR_RESP_SLVERR = 2'b10;
endpackage : prr_pkg

// File: common/prr_reg_if.sv
/*
 * Interface carrying register writes and read data between the bus slave
 * and the port register bank.
 * Assumes a single clock shared by both ends.
 */
`timescale 1ns/1ns
interface prr_reg_if;
  logic wr_en;
  logic rd_en;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [31:0] rdata;
  logic hit;
  modport bus (output wr_en, rd_en, addr, wdata, wstrb, input rdata, hit);
  modport regs (input wr_en, rd_en, addr, wdata, wstrb, output rdata, hit);
endinterface : prr_reg_if

// File: hw/prr_axil_slave.sv
/*
 * AXI4-Lite slave: takes one write and one read at a time and hands
 * them to the register bank as single-cycle strobes.
 * Assumes the register bank answers reads combinationally.
 */
`timescale 1ns/1ns
module prr_axil_slave (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register bank side
  prr_reg_if.bus rb
);
  import prr_pkg::*;

  logic aw_have_reg, aw_have_next;
  logic w_have_reg, w_have_next;
  logic [11:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic do_wr, do_rd;

  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg && !do_wr;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // Write fires once both halves are held; reads wait a cycle behind it
  assign do_wr = aw_have_reg && w_have_reg;
  assign do_rd = s_axi_arvalid && s_axi_arready;
  assign rb.wr_en = do_wr;
  assign rb.rd_en = do_rd;
  assign rb.addr = do_wr ? awaddr_reg : s_axi_araddr;
  assign rb.wdata = wdata_reg;
  assign rb.wstrb = wstrb_reg;

  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = rb.hit ? PRR_RESP_OKAY : PRR_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (do_rd) begin
      rvalid_next = 1'b1;
      rdata_next = rb.hit ? rb.rdata : 32'h0000_0000;
      rresp_next = rb.hit ? PRR_RESP_OKAY : PRR_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'b00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule : prr_axil_slave

// File: hw/prr_pin_sync.sv
/*
 * Two-stage synchroniser for the pad input levels of every port.
 * Assumes the pins are asynchronous to clk_sys.
 */
`timescale 1ns/1ns
module prr_pin_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pins
  input wire logic [prr_pkg::PRR_NPORT*prr_pkg::PRR_PW-1:0] pin_async,
  output logic [prr_pkg::PRR_NPORT*prr_pkg::PRR_PW-1:0] pin_sync
);
  import prr_pkg::*;

  logic [PRR_NPORT*PRR_PW-1:0] meta_reg, meta_next;
  logic [PRR_NPORT*PRR_PW-1:0] sync_reg, sync_next;

  always_comb begin
    meta_next = pin_async;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign pin_sync = sync_reg;
endmodule : prr_pin_sync

// File: hw/prr_port_regs.sv
/*
 * Port register bank with system reset and a separate port module reset,
 * plus the digital input gate of the shared analog/digital pins.
 * Assumes AXI4-Lite access at 20 MHz; pins arrive asynchronously.
 */
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
// Behaviour
// - Software bit triggers port-only register reset
// - Upper pin control: zero, module reset 2020_2020
// - Pad drivers: 2222_2222, module reset zero
// - Input-disable bits gate analog-port digital inputs
// - System reset disables, module reset enables inputs
// - Pure digital port input-disable is read-only
// - Input-disable loads availability, module reset zero
// - Second analog port bits 4,5 stay zero
// - Disabled pin level never reaches internal logic
// - Disabled analog port pins give no scan capture
`timescale 1ns/1ns
module prr_port_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and internal consumers
  input wire logic [prr_pkg::PRR_NPORT*prr_pkg::PRR_PW-1:0] pin_in,
  output logic [prr_pkg::PRR_NPORT*prr_pkg::PRR_PW-1:0] pin_to_core,
  output logic [prr_pkg::PRR_NPORT*prr_pkg::PRR_PW-1:0] pin_to_scan,
  // Pad configuration
  output logic [prr_pkg::PRR_NPORT*32-1:0] upper_pin_control,
  output logic [prr_pkg::PRR_NPORT*32-1:0] pad_driver_low,
  output logic [prr_pkg::PRR_NPORT*32-1:0] pad_driver_high,
  // Module reset pulse, for observation
  output logic port_module_reset
);
  import prr_pkg::*;

  prr_reg_if rb ();

  prr_axil_slave u_slave (
    .clk_sys(clk_sys),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rb(rb.bus)
  );

  logic [PRR_NPORT*PRR_PW-1:0] pin_sync;

  prr_pin_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_async(pin_in),
    .pin_sync(pin_sync)
  );

  // Module reset request: one-cycle pulse applied the cycle after the write
  logic mod_rst_reg, mod_rst_next;
  logic mod_rst_seen_reg, mod_rst_seen_next;
  logic wr_prs;

  assign wr_prs = rb.wr_en && rb.addr == PRR_OFF_PERIPHERAL_RESET_SET
    && rb.wstrb[0] && rb.wdata[PRR_BIT_PORT_RESET_REQUEST];

  always_comb begin
    mod_rst_next = wr_prs;
    mod_rst_seen_next = mod_rst_seen_reg;
    if (mod_rst_reg) begin
      mod_rst_seen_next = 1'b1;
    end
    if (rb.wr_en && rb.addr == PRR_OFF_RESET_STATUS && rb.wstrb[0] && rb.wdata[0]) begin
      mod_rst_seen_next = 1'b0;
    end
    if (mod_rst_reg) begin
      mod_rst_seen_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mod_rst_reg <= 1'b0;
      mod_rst_seen_reg <= 1'b0;
    end else begin
      mod_rst_reg <= mod_rst_next;
      mod_rst_seen_reg <= mod_rst_seen_next;
    end
  end

  assign port_module_reset = mod_rst_reg;

  logic [31:0] port_rdata [PRR_NPORT];
  logic [PRR_NPORT-1:0] port_hit;

  genvar gp;
  generate
    for (gp = 0; gp < PRR_NPORT; gp++) begin : g_port
      localparam logic [11:0] BASE = 12'(gp) * PRR_SLOT_STRIDE;
      localparam bit ANALOG = (gp == PRR_ANA_A) || (gp == PRR_ANA_B);
      localparam logic [15:0] LOCK = (gp == PRR_ANA_B) ? PRR_ANA_B_LOCK : 16'h0000;
      logic [31:0] upc_reg, upc_next;
      logic [31:0] pdl_reg, pdl_next;
      logic [31:0] pdh_reg, pdh_next;
      logic [15:0] did_reg, did_next;
      logic sel;
      logic [2:0] idx;
      logic [15:0] pins;
      logic [31:0] did_wr;

      assign sel = rb.addr >= BASE && rb.addr < BASE + PRR_SLOT_STRIDE;
      assign idx = rb.addr[4:2] - 3'h0;

      function automatic logic [31:0] merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
          if (be[b]) begin
            res[8*b +: 8] = wd[8*b +: 8];
          end
        end
        return res;
      endfunction : merge

      // Merged word kept apart so only its low half is taken
      assign did_wr = merge({16'h0000, did_reg}, rb.wdata, rb.wstrb);

      always_comb begin
        upc_next = upc_reg;
        pdl_next = pdl_reg;
        pdh_next = pdh_reg;
        did_next = did_reg;
        if (rb.wr_en && sel) begin
          case (idx)
            PRR_IDX_UPPER_PIN_CONTROL: upc_next = merge(upc_reg, rb.wdata, rb.wstrb);
            PRR_IDX_PAD_DRIVER_LOW: pdl_next = merge(pdl_reg, rb.wdata, rb.wstrb);
            PRR_IDX_PAD_DRIVER_HIGH: pdh_next = merge(pdh_reg, rb.wdata, rb.wstrb);
            PRR_IDX_DIGITAL_INPUT_DISABLE: begin
              if (ANALOG) begin
                did_next = did_wr[PRR_PW-1:0] & ~LOCK;
              end
            end
            default: ;
          endcase
        end
        // Module reset outranks a write landing in the same cycle
        if (mod_rst_reg) begin
          upc_next = PRR_UPC_MOD_RST;
          pdl_next = PRR_PDR_MOD_RST;
          pdh_next = PRR_PDR_MOD_RST;
          did_next = PRR_DID_MOD_RST[PRR_PW-1:0];
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          upc_reg <= PRR_UPC_SYS_RST;
          pdl_reg <= PRR_PDR_SYS_RST;
          pdh_reg <= PRR_PDR_SYS_RST;
          did_reg <= PRR_DID_SYS_RST[gp] & ~LOCK;
        end else begin
          upc_reg <= upc_next;
          pdl_reg <= pdl_next;
          pdh_reg <= pdh_next;
          did_reg <= did_next;
        end
      end

      // Disabled analog inputs read zero inside and in the scan chain
      assign pins = ANALOG ? (pin_sync[gp*PRR_PW +: PRR_PW] & ~did_reg)
                           : pin_sync[gp*PRR_PW +: PRR_PW];
      assign pin_to_core[gp*PRR_PW +: PRR_PW] = pins;
      assign pin_to_scan[gp*PRR_PW +: PRR_PW] = pins;
      assign upper_pin_control[gp*32 +: 32] = upc_reg;
      assign pad_driver_low[gp*32 +: 32] = pdl_reg;
      assign pad_driver_high[gp*32 +: 32] = pdh_reg;
      assign port_hit[gp] = sel && idx <= PRR_IDX_PIN_INPUT;

      always_comb begin
        case (idx)
          PRR_IDX_UPPER_PIN_CONTROL: port_rdata[gp] = upc_reg;
          PRR_IDX_DIGITAL_INPUT_DISABLE: port_rdata[gp] = {16'h0000, did_reg};
          PRR_IDX_PAD_DRIVER_LOW: port_rdata[gp] = pdl_reg;
          PRR_IDX_PAD_DRIVER_HIGH: port_rdata[gp] = pdh_reg;
          PRR_IDX_PIN_INPUT: port_rdata[gp] = {16'h0000, pins};
          default: port_rdata[gp] = 32'h0000_0000;
        endcase
      end
    end
  endgenerate

  always_comb begin
    rb.rdata = 32'h0000_0000;
    rb.hit = 1'b0;
    for (int p = 0; p < PRR_NPORT; p++) begin
      if (port_hit[p]) begin
        rb.rdata = port_rdata[p];
        rb.hit = 1'b1;
      end
    end
    if (rb.addr == PRR_OFF_PERIPHERAL_RESET_SET) begin
      rb.hit = 1'b1;
    end
    if (rb.addr == PRR_OFF_RESET_STATUS) begin
      rb.rdata = {31'h0000_0000, mod_rst_seen_reg};
      rb.hit = 1'b1;
    end
  end
endmodule : prr_port_regs

// File: test/prr_port_regs_sva.sv
/* Checker for prr_port_regs: reset values, module reset pulse, pin gating.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ns
module prr_port_regs_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Observed ports
  input wire logic [63:0] pin_in,
  input wire logic [63:0] pin_to_core,
  input wire logic [63:0] pin_to_scan,
  input wire logic [127:0] upper_pin_control,
  input wire logic [127:0] pad_driver_low,
  input wire logic [127:0] pad_driver_high,
  input wire logic port_module_reset
);
  import prr_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_MOD_UPC: assert property (
    port_module_reset |=> upper_pin_control == {4{PRR_UPC_MOD_RST}})
    else $error("upper pin control wrong after module reset");
  AST_MOD_PDR: assert property (
    port_module_reset |=> (pad_driver_low | pad_driver_high) == '0)
    else $error("pad drivers not cleared by module reset");
  AST_SYS_VAL: assert property (
    $fell(rst) |-> upper_pin_control == {4{PRR_UPC_SYS_RST}}
      && pad_driver_low == {4{PRR_PDR_SYS_RST}} && pad_driver_high == {4{PRR_PDR_SYS_RST}})
    else $error("system reset values wrong");
  AST_SCAN_SYS: assert property (
    $fell(rst) |-> ##3 (pin_to_scan[47:32] == 16'h0000
      && (pin_to_scan[63:48] & ~PRR_ANA_B_LOCK) == 16'h0000))
    else $error("analog pins visible to scan after reset");
  AST_SCAN_CORE: assert property (pin_to_scan == pin_to_core)
    else $error("scan capture differs from core view");
  // Two sync stages, so only judged once reset is two edges old
  AST_DIG_PASS: assert property (
    !$past(rst) && !$past(rst, 2) |-> pin_to_core[31:0] == $past(pin_in[31:0], 2))
    else $error("digital port level not passed through");
  AST_GATE: assert property (
    !$past(rst) && !$past(rst, 2) |-> (pin_to_core & ~$past(pin_in, 2)) == '0)
    else $error("pin level reaches core when not present at pad");
  AST_MOD_EN: assert property (
    port_module_reset |=> pin_to_core[63:32] == $past(pin_in[63:32], 2))
    else $error("analog inputs not enabled after module reset");
  AST_PULSE: assert property (
    port_module_reset |=> !port_module_reset [*2])
    else $error("module reset pulse too long");
endmodule : prr_port_regs_sva

bind prr_port_regs prr_port_regs_sva u_sva (.clk_sys, .rst, .pin_in, .pin_to_core,
  .pin_to_scan, .upper_pin_control, .pad_driver_low, .pad_driver_high, .port_module_reset);

// File: test/prr_pin_model.sv
/* Pad model for prr_port_regs: drives the pin levels the bench asks for.
   Assumes levels are unrelated to clk_sys, so a skew is added. */
`timescale 1ns/1ns
module prr_pin_model (
  // Requested levels
  input wire logic [63:0] level,
  // Pads
  output logic [63:0] pin_in
);
  // Skew keeps pad edges off the sampling edge
  // Runs once at time zero as well, so the pads are driven from 7 ns on
  always begin
    pin_in <= #7 level;
    @(level);
  end
endmodule : prr_pin_model

// File: test/prr_port_regs_tb_top.sv
/* Bench for prr_port_regs: register access, both resets, pin gating.
   Assumes the pad model and the bound checker are compiled alongside. */
`timescale 1ns/1ns
module prr_port_regs_tb_top;
  import prr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [63:0] level = 64'h0000_0000_0000_0000;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire port_module_reset;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [63:0] pin_in, pin_to_core, pin_to_scan;
  wire [127:0] upper_pin_control, pad_driver_low, pad_driver_high;
  int bad_count = 0;
  int n_checks = 0;

  always #25 clk_sys = ~clk_sys;

  prr_port_regs uut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_to_core, .pin_to_scan,
    .upper_pin_control, .pad_driver_low, .pad_driver_high, .port_module_reset);
  prr_pin_model pads (.level, .pin_in);

  task automatic summarize;
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (!aw && !w && s_axi_bvalid === 1'b1) break;
    end
    if (i == 40) begin
      bad_count++;
      summarize();
    end
    // Ready stays up between calls, and each call drives it high again
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int i;
    logic ar;
    ar = 1'b1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (!ar && s_axi_rvalid === 1'b1) break;
      if (ar && s_axi_arready === 1'b1) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
    if (i == 40) begin
      bad_count++;
      summarize();
    end
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd

  // Reads four of every port's five registers, skipping pin input; did_sys picks the availability masks
  task automatic chk_regs(input logic [31:0] upc, input logic did_sys, input logic [31:0] pdr);
    logic [11:0] b;
    for (int p = 0; p < 4; p++) begin
      b = 12'(p * 32);
      rd(b, upc, PRR_RESP_OKAY);
      rd(b + 12'h004, did_sys ? {16'h0000, PRR_DID_SYS_RST[p] &
        (p == 3 ? ~PRR_ANA_B_LOCK : 16'hffff)} : PRR_DID_MOD_RST, PRR_RESP_OKAY);
      rd(b + 12'h008, pdr, PRR_RESP_OKAY);
      rd(b + 12'h00c, pdr, PRR_RESP_OKAY);
    end
  endtask : chk_regs

  task automatic sys_reset;
    rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
  endtask : sys_reset

  task automatic set_pins(input logic [63:0] v);
    level <= v;
    repeat (4) @(posedge clk_sys);
  endtask : set_pins

  task automatic t_sys_values;
    chk_regs(PRR_UPC_SYS_RST, 1'b1, PRR_PDR_SYS_RST);
    set_pins({64{1'b1}});
    chk(pin_to_scan[63:32], {PRR_ANA_B_LOCK, 16'h0000});
    chk(pin_to_core[31:0], 32'hffff_ffff);
  endtask : t_sys_values

  task automatic t_input_disable;
    wr(12'h004, 32'h0000_0000, PRR_RESP_OKAY);
    rd(12'h004, {16'h0000, PRR_DID_SYS_RST[0]}, PRR_RESP_OKAY);
    wr(12'h024, 32'h0000_0000, PRR_RESP_OKAY);
    rd(12'h024, {16'h0000, PRR_DID_SYS_RST[1]}, PRR_RESP_OKAY);
    wr(12'h064, 32'hffff_ffff, PRR_RESP_OKAY);
    rd(12'h064, 32'h0000_ffcf, PRR_RESP_OKAY);
    wr(12'h044, 32'h0000_0000, PRR_RESP_OKAY);
    set_pins({16'h0000, 16'ha5c3, 32'h0000_0000});
    chk(pin_to_core[63:32], 32'h0000_a5c3);
    rd(12'h050, 32'h0000_a5c3, PRR_RESP_OKAY);
    wr(12'h044, 32'h0000_ffff, PRR_RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    chk(pin_to_core[63:32], 32'h0000_0000);
  endtask : t_input_disable

  task automatic t_unmapped;
    rd(12'h0f0, 32'h0000_0000, PRR_RESP_SLVERR);
    wr(12'h0f0, 32'h1234_5678, PRR_RESP_SLVERR);
  endtask : t_unmapped

  task automatic t_module_reset;
    wr(12'h020, 32'h1234_5678, PRR_RESP_OKAY);
    wr(PRR_OFF_PERIPHERAL_RESET_SET, 32'h0000_0001, PRR_RESP_OKAY);
    chk_regs(PRR_UPC_MOD_RST, 1'b0, PRR_PDR_MOD_RST);
    rd(PRR_OFF_RESET_STATUS, 32'h0000_0001, PRR_RESP_OKAY);
    wr(PRR_OFF_RESET_STATUS, 32'h0000_0001, PRR_RESP_OKAY);
    rd(PRR_OFF_RESET_STATUS, 32'h0000_0000, PRR_RESP_OKAY);
    set_pins({64{1'b1}});
    chk(pin_to_scan[63:32], 32'hffff_ffff);
    // Privileged software restores the soft-edge low driver of port 0
    wr(12'h008, PRR_PDR_SYS_RST, PRR_RESP_OKAY);
    rd(12'h008, PRR_PDR_SYS_RST, PRR_RESP_OKAY);
  endtask : t_module_reset

  initial begin
    sys_reset();
    t_sys_values();
    t_input_disable();
    t_unmapped();
    t_module_reset();
    // Pads held high across the reset so the analog gate is really tested
    set_pins({64{1'b1}});
    sys_reset();
    t_sys_values();
    summarize();
  end
endmodule : prr_port_regs_tb_top
